// file: rtl/pin_mux_pkg.sv
// shared types and constants for the pin pull and port mux block
package pin_mux_pkg;
    localparam int PIN_COUNT       = 16;
    localparam int PORT1_COUNT     = 4;
    localparam int PORT4_COUNT     = 4;
    localparam int PORT8_COUNT     = 2;
    localparam int PORT16_COUNT    = 1;
    localparam int PORT4_WIDTH     = 4;
    localparam int PORT8_WIDTH     = 8;
    localparam int PORT16_WIDTH    = 16;
    localparam int LINK_COUNT      = 1;
    localparam int LINK_PIN_BASE   = 12;
    localparam int LINK_PIN_WIDTH  = 4;
    localparam logic PULL_RESET_ON = 1'b1;
    localparam logic DIR_IN        = 1'b0;
    localparam logic DIR_OUT       = 1'b1;

    // one software pull request: per-pin write strobe and value
    typedef struct packed {
        logic [PIN_COUNT-1:0] write_en;
        logic [PIN_COUNT-1:0] value;
    } pull_write_type;

    // owner of a pin after arbitration
    typedef enum logic [2:0] {
        OWN_NONE,
        OWN_LINK,
        OWN_P1,
        OWN_P4,
        OWN_P8,
        OWN_P16
    } owner_type;
endpackage : pin_mux_pkg

// file: rtl/pin_pull_bit.sv
// one pin's weak pull state bit
`timescale 1ns/100ps
module pin_pull_bit (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic claimed_i,
    input  wire logic sw_write_i,
    input  wire logic sw_value_i,
    output logic      pull_on_o
);
    logic claimed_r;
    logic pull_r;
    logic pull_nxt;
    wire  claim_edge = claimed_i & ~claimed_r;

    // software write wins once claimed; a fresh claim turns it off
    assign pull_nxt = (claimed_i & sw_write_i) ? sw_value_i :
                      claim_edge ? 1'b0 : pull_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pull_r    <= pin_mux_pkg::PULL_RESET_ON;
            claimed_r <= 1'b0;
        end else begin
            pull_r    <= pull_nxt;
            claimed_r <= claimed_i;
        end
    end

    assign pull_on_o = pull_r;
endmodule : pin_pull_bit

// file: rtl/io_pin_pull_and_port_mux.sv
// pin ownership arbitration, shared port direction and weak pull control
`timescale 1ns/100ps
module io_pin_pull_and_port_mux #(
    parameter int PINS = pin_mux_pkg::PIN_COUNT
) (
    input  wire logic                               clock_i,
    input  wire logic                               rst_n_i,
    input  wire logic [pin_mux_pkg::PORT1_COUNT-1:0]  p1_en_i,
    input  wire logic [pin_mux_pkg::PORT4_COUNT-1:0]  p4_en_i,
    input  wire logic [pin_mux_pkg::PORT8_COUNT-1:0]  p8_en_i,
    input  wire logic [pin_mux_pkg::PORT16_COUNT-1:0] p16_en_i,
    input  wire logic                               link_en_i,
    input  wire logic [pin_mux_pkg::PORT1_COUNT-1:0]  p1_dir_i,
    input  wire logic [pin_mux_pkg::PORT4_COUNT-1:0]  p4_dir_i,
    input  wire logic [pin_mux_pkg::PORT8_COUNT-1:0]  p8_dir_i,
    input  wire logic [pin_mux_pkg::PORT16_COUNT-1:0] p16_dir_i,
    input  wire logic [PINS-1:0]                    p1_dout_i,
    input  wire logic [PINS-1:0]                    p4_dout_i,
    input  wire logic [PINS-1:0]                    p8_dout_i,
    input  wire logic [PINS-1:0]                    p16_dout_i,
    input  wire logic [PINS-1:0]                    link_dout_i,
    input  wire logic [PINS-1:0]                    link_oe_i,
    input  wire pin_mux_pkg::pull_write_type        pull_wr_i,
    output logic      [PINS-1:0]                    pin_out_o,
    output logic      [PINS-1:0]                    pin_oe_o,
    output logic      [PINS-1:0]                    weak_pulldown_o,
    output logic      [PINS-1:0]                    pin_claimed_o,
    output logic                                    chip_reset_o
);
    // =====================================================================
    // elaboration checks: the pin map is fixed at this geometry
    if (PINS != pin_mux_pkg::PIN_COUNT) begin : g_bad_pins
        $error("PINS must equal the fixed pin map width");
    end

    if (pin_mux_pkg::PORT1_COUNT > PINS) begin : g_bad_p1
        $error("more single-bit ports than pins");
    end

    if (pin_mux_pkg::PORT4_COUNT * pin_mux_pkg::PORT4_WIDTH != PINS) begin : g_bad_p4
        $error("4-bit ports must tile the pin map");
    end

    if (pin_mux_pkg::PORT8_COUNT * pin_mux_pkg::PORT8_WIDTH != PINS) begin : g_bad_p8
        $error("8-bit ports must tile the pin map");
    end

    if (pin_mux_pkg::PORT16_COUNT * pin_mux_pkg::PORT16_WIDTH != PINS) begin : g_bad_p16
        $error("the 16-bit port must cover the pin map");
    end

    if (pin_mux_pkg::LINK_COUNT != 1) begin : g_bad_links
        $error("exactly one link is served");
    end

    if (pin_mux_pkg::LINK_PIN_BASE + pin_mux_pkg::LINK_PIN_WIDTH > PINS) begin : g_bad_link_pins
        $error("link pins run past the pin map");
    end

    if (pin_mux_pkg::DIR_OUT == pin_mux_pkg::DIR_IN) begin : g_bad_dir
        $error("direction codes must differ");
    end

    // =====================================================================
    // per-pin nets
    logic [PINS-1:0]    link_pin;
    logic [PINS-1:0]    en1_pin;
    logic [PINS-1:0]    en4_pin;
    logic [PINS-1:0]    en8_pin;
    logic [PINS-1:0]    en16_pin;

    logic [PINS-1:0]    dir1_pin;
    logic [PINS-1:0]    dir4_pin;
    logic [PINS-1:0]    dir8_pin;
    logic [PINS-1:0]    dir16_pin;

    logic [PINS-1:0]    claimed;
    logic [PINS-1:0]    pull_on;
    logic [PINS-1:0]    out_nxt;
    logic [PINS-1:0]    oe_nxt;

    // =====================================================================
    // per-pin decode, ownership, selection and pull state
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            localparam bit HAS1   = (g < pin_mux_pkg::PORT1_COUNT);
            localparam bit ONLINK = (g >= pin_mux_pkg::LINK_PIN_BASE) &&
                                    (g < pin_mux_pkg::LINK_PIN_BASE + pin_mux_pkg::LINK_PIN_WIDTH);
            localparam int I1     = HAS1 ? g : 0;
            localparam int I4     = g / pin_mux_pkg::PORT4_WIDTH;
            localparam int I8     = g / pin_mux_pkg::PORT8_WIDTH;
            localparam int I16    = g / pin_mux_pkg::PORT16_WIDTH;
            pin_mux_pkg::owner_type owner;
            logic                   sel_link;
            logic                   sel_p1;
            logic                   sel_p4;
            logic                   sel_p8;
            logic                   sel_p16;

            // which ports and link reach this pin
            assign link_pin[g]  = ONLINK & link_en_i;
            assign en1_pin[g]   = HAS1 & p1_en_i[I1];
            assign en4_pin[g]   = p4_en_i[I4];
            assign en8_pin[g]   = p8_en_i[I8];
            assign en16_pin[g]  = p16_en_i[I16];
            assign dir1_pin[g]  = HAS1 & p1_dir_i[I1];
            assign dir4_pin[g]  = p4_dir_i[I4];
            assign dir8_pin[g]  = p8_dir_i[I8];
            assign dir16_pin[g] = p16_dir_i[I16];

            // link above all, then the narrowest enabled port
            assign owner = link_pin[g] ? pin_mux_pkg::OWN_LINK :
                           en1_pin[g]  ? pin_mux_pkg::OWN_P1 :
                           en4_pin[g]  ? pin_mux_pkg::OWN_P4 :
                           en8_pin[g]  ? pin_mux_pkg::OWN_P8 :
                           en16_pin[g] ? pin_mux_pkg::OWN_P16 :
                                         pin_mux_pkg::OWN_NONE;
            assign sel_link   = (owner == pin_mux_pkg::OWN_LINK);
            assign sel_p1     = (owner == pin_mux_pkg::OWN_P1);
            assign sel_p4     = (owner == pin_mux_pkg::OWN_P4);
            assign sel_p8     = (owner == pin_mux_pkg::OWN_P8);
            assign sel_p16    = (owner == pin_mux_pkg::OWN_P16);
            assign claimed[g] = (owner != pin_mux_pkg::OWN_NONE);

            // data and enable follow the owner; one direction per port
            assign out_nxt[g] = sel_link ? link_dout_i[g] :
                                sel_p1   ? p1_dout_i[g] :
                                sel_p4   ? p4_dout_i[g] :
                                sel_p8   ? p8_dout_i[g] :
                                sel_p16  ? p16_dout_i[g] :
                                           1'b0;
            assign oe_nxt[g]  = sel_link ? link_oe_i[g] :
                                sel_p1   ? dir1_pin[g] :
                                sel_p4   ? dir4_pin[g] :
                                sel_p8   ? dir8_pin[g] :
                                sel_p16  ? dir16_pin[g] :
                                           pin_mux_pkg::DIR_IN;

            // weak pull state of this pin
            pin_pull_bit u_pull (
                .clock_i    (clock_i),
                .rst_n_i    (rst_n_i),
                .claimed_i  (claimed[g]),
                .sw_write_i (pull_wr_i.write_en[g]),
                .sw_value_i (pull_wr_i.value[g]),
                .pull_on_o  (pull_on[g])
            );
        end
    endgenerate

    // =====================================================================
    // output registers
    // driven pin levels
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_out_o <= '0;
        end else begin
            pin_out_o <= out_nxt;
        end
    end

    // pin output enables
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_oe_o <= '0;
        end else begin
            pin_oe_o <= oe_nxt;
        end
    end

    // weak pull state per pin
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            weak_pulldown_o <= {PINS{pin_mux_pkg::PULL_RESET_ON}};
        end else begin
            weak_pulldown_o <= pull_on;
        end
    end

    // pin ownership status
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_claimed_o <= '0;
        end else begin
            pin_claimed_o <= claimed;
        end
    end

    // chip held in reset while the input is low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_reset_o <= 1'b1;
        end else begin
            chip_reset_o <= 1'b0;
        end
    end
endmodule : io_pin_pull_and_port_mux

// file: tb/pin_board.sv
// board model: pads with weak pull-downs
`timescale 1ns/100ps
module pin_board (
    input  wire logic        clock_i,
    input  wire logic [15:0] pin_out_i,
    input  wire logic [15:0] pin_oe_i,
    input  wire logic [15:0] weak_pulldown_i,
    output logic      [15:0] pad_o
);
    logic [15:0] float_r = 16'h0000;
    // an unheld pad toggles, never a clean level
    always @(posedge clock_i) begin
        float_r <= ~float_r;
    end
    assign pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ~weak_pulldown_i & float_r);
endmodule : pin_board

// file: tb/pin_mux_properties.sv
// port checker for the pin mux
`timescale 1ns/100ps
module pin_mux_checker (
    input wire logic [3:0]  p1_en_i,
    input wire logic [3:0]  p1_dir_i,
    input wire logic [3:0]  p4_en_i,
    input wire logic [3:0]  p4_dir_i,
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        link_en_i,
    input wire logic [15:0] link_oe_i,
    input wire pin_mux_pkg::pull_write_type pull_wr_i,
    input wire logic [15:0] pin_oe_o,
    input wire logic [15:0] weak_pulldown_o,
    input wire logic [15:0] pin_claimed_o,
    input wire logic        chip_reset_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_sw_write;
        pin_claimed_o[0] && pull_wr_i.write_en[0] ##1 !pull_wr_i.write_en[0];
    endsequence
    property p_run; $past(rst_n_i) |-> !chip_reset_o; endproperty
    property p_wake; $rose(rst_n_i) |-> &weak_pulldown_o && pin_oe_o == 16'h0000; endproperty
    property p_guard;
        (~weak_pulldown_o & $past(weak_pulldown_o) & ~($past(pin_claimed_o) | $past(pin_claimed_o, 2))) == 16'h0000;
    endproperty
    property p_link; link_en_i |=> pin_claimed_o[15:12] == 4'hF && pin_oe_o[15:12] == $past(link_oe_i[15:12]); endproperty
    property p_narrow; p1_en_i[0] && !link_en_i |=> pin_oe_o[0] == $past(p1_dir_i[0]); endproperty
    property p_dir; p4_en_i[1] |=> pin_oe_o[7:4] == {4{$past(p4_dir_i[1])}}; endproperty
    property p_clr; $rose(pin_claimed_o[4]) && !$past(pull_wr_i.write_en[4]) |-> ##[1:2] !weak_pulldown_o[4]; endproperty
    property p_sw; s_sw_write |-> ##1 weak_pulldown_o[0] == $past(pull_wr_i.value[0], 2); endproperty
    a_run: assert property (p_run) else $error("chip reset held");
    a_wake: assert property (p_wake) else $error("pull off at reset");
    a_guard: assert property (p_guard) else $error("pull fell unclaimed");
    a_link: assert property (p_link) else $error("link pins wrong");
    a_narrow: assert property (p_narrow) else $error("narrow port lost");
    a_dir: assert property (p_dir) else $error("port direction split");
    a_clr: assert property (p_clr) else $error("claim kept pull");
    a_sw: assert property (p_sw) else $error("pull write lost");
endmodule : pin_mux_checker
bind io_pin_pull_and_port_mux pin_mux_checker u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .p1_en_i(p1_en_i),
    .p1_dir_i(p1_dir_i), .p4_en_i(p4_en_i), .p4_dir_i(p4_dir_i), .link_en_i(link_en_i), .link_oe_i(link_oe_i),
    .pull_wr_i(pull_wr_i), .pin_oe_o(pin_oe_o), .weak_pulldown_o(weak_pulldown_o),
    .pin_claimed_o(pin_claimed_o), .chip_reset_o(chip_reset_o));

// file: tb/io_pin_pull_and_port_mux_bench.sv
// bench for the pin mux
`timescale 1ns/100ps
module io_pin_pull_and_port_mux_bench;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] p1_en = 4'h0, p4_en = 4'h0, p1_dir = 4'h3, p4_dir = 4'h5;
    logic [1:0] p8_en = 2'h0, p8_dir = 2'h1;
    logic p16_en = 1'b0, link_en = 1'b0;
    logic [15:0] dv = 16'hFFFF, lnk = 16'hF000;
    pin_mux_pkg::pull_write_type pw = '0;
    logic [15:0] pin_out, pin_oe, pulls, claimed, pad;
    logic chip_reset;
    int mismatches = 0, checked = 0;
    initial forever #2.5 clock_i = ~clock_i;
    io_pin_pull_and_port_mux u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .p1_en_i(p1_en), .p4_en_i(p4_en),
        .p8_en_i(p8_en), .p16_en_i(p16_en), .link_en_i(link_en), .p1_dir_i(p1_dir), .p4_dir_i(p4_dir),
        .p8_dir_i(p8_dir), .p16_dir_i(p8_dir[0]), .p1_dout_i(~dv), .p4_dout_i(dv), .p8_dout_i(~dv),
        .p16_dout_i(dv), .link_dout_i(lnk ^ 16'h5000), .link_oe_i(lnk), .pull_wr_i(pw), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .weak_pulldown_o(pulls), .pin_claimed_o(claimed), .chip_reset_o(chip_reset));
    pin_board u_board (.clock_i(clock_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .weak_pulldown_i(pulls),
        .pad_o(pad));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait3;
        repeat (3) @(negedge clock_i);
    endtask : wait3
    task automatic step(input logic [3:0] e1, input logic [3:0] e4, input logic [1:0] e8, input logic e16,
                        input logic el, input logic [15:0] oe, input logic [15:0] dr);
        @(negedge clock_i);
        {p1_en, p4_en, p8_en, p16_en, link_en} = {e1, e4, e8, e16, el};
        wait3();
        chk("oe", pin_oe, oe);
        chk("pad", pad & pin_oe, dr);
    endtask : step
    task automatic t_reset;
        @(negedge clock_i);
        rst_n_i = 1'b0;
        @(negedge clock_i);
        chk("pull rst", pulls, 16'hFFFF);
        chk("pad rst", pad, 16'h0000);
        chk("chip rst", {15'h0, chip_reset}, 16'h0001);
        rst_n_i = 1'b1;
        wait3();
        chk("chip run", {15'h0, chip_reset}, 16'h0000);
        chk("pull run", pulls, 16'hFFFF);
    endtask : t_reset
    task automatic t_ports;
        step(4'h0, 4'h1, 2'h1, 1'b0, 1'b0, 16'h00FF, 16'h000F);
        chk("pull part", pulls, 16'hFF00);
        step(4'h0, 4'h0, 2'h0, 1'b1, 1'b0, 16'hFFFF, 16'hFFFF);
        step(4'h0, 4'h0, 2'h3, 1'b1, 1'b0, 16'h00FF, 16'h0000);
        step(4'h0, 4'hF, 2'h3, 1'b1, 1'b0, 16'h0F0F, 16'h0F0F);
        step(4'hF, 4'hF, 2'h3, 1'b1, 1'b0, 16'h0F03, 16'h0F00);
        step(4'hF, 4'hF, 2'h3, 1'b1, 1'b1, 16'hFF03, 16'hAF00);
        chk("claimed", claimed, 16'hFFFF);
        chk("pull all", pulls, 16'h0000);
    endtask : t_ports
    task automatic t_pull(input logic [15:0] en, input logic [15:0] val, input logic [15:0] exp);
        @(negedge clock_i);
        pw = {en, val};
        @(negedge clock_i);
        pw = '0;
        wait3();
        chk("pull sw", pulls, exp);
    endtask : t_pull
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    initial begin
        #5000;
        mismatches++;
        results();
    end
    initial begin
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_ports();
        t_pull(16'h0101, 16'h0101, 16'h0101);
        t_pull(16'h0100, 16'h0000, 16'h0001);
        step(4'h0, 4'h0, 2'h0, 1'b0, 1'b0, 16'h0000, 16'h0000);
        t_pull(16'h0101, 16'h0100, 16'h0001);
        t_reset();
        results();
    end
endmodule : io_pin_pull_and_port_mux_bench
